//--- hw/dual_timer.v
// dual timer/counter control, mode logic and apb register file
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "timer_regs.vh"

module dual_timer (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_B,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg PREADY,
  output reg [31:0] PRDATA,
  output reg PSLVERR,
  // external pins
  input wire FIRST_EXT_IRQ_PIN,
  input wire SECOND_EXT_IRQ_PIN,
  input wire FIRST_COUNT_PIN,
  input wire SECOND_COUNT_PIN,
  // interrupt vector acknowledges from the processor
  input wire FIRST_OVF_ACK,
  input wire SECOND_OVF_ACK,
  input wire FIRST_EDGE_ACK,
  input wire SECOND_EDGE_ACK,
  // flags and interrupt
  output reg FIRST_OVERFLOW_FLAG,
  output reg SECOND_OVERFLOW_FLAG,
  output reg FIRST_EDGE_FLAG,
  output reg SECOND_EDGE_FLAG,
  output reg IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg [7:0] ctl_q;
  reg [7:0] mod_q;
  reg [7:0] xmode_q;
  reg [7:0] tl0_q, th0_q, tl1_q, th1_q;
  reg [7:0] rl0_q, rh0_q, rl1_q, rh1_q;
  reg [3:0] status_q;
  reg [3:0] enable_q;
  reg irq0_prev_q, irq1_prev_q, cnt0_prev_q, cnt1_prev_q;
  reg [7:0] ctl_d;
  reg [31:0] rdata;
  reg hit;

  ////////////////////////////////////////////////////////////////////////////
  // one counting step of one timer: returns {overflow, high, low}
  // the same function serves both timers, so the two count alike in modes 00, 01 and 10
  // mode 00: only the lowest wid+1 bits of the low byte count; the rest read 0
  // mode 01: high and low bytes form one 16-bit counter with a 16-bit reload
  // mode 10: low byte counts alone and reloads from the high byte
  // mode 11: low byte counts alone; for the first timer the caller steps the high byte itself
  // limitation: no prescaler here, so a tick is one clock or one pin fall

  function [16:0] step;
    input [1:0] mode;
    input [2:0] wid;
    input tick;
    input [7:0] tl;
    input [7:0] th;
    input [7:0] rl;
    input [7:0] rh;
    reg [7:0] mask;
    begin
      mask = 8'hFF >> (3'h7 - wid);
      step = {1'b0, th, tl};
      if (tick) begin
        case (mode)
          `MODE_VAR: begin
            // only wid+1 low bits take part; upper low bits are cleared
            if ((tl & mask) == mask)
              step = {(th == 8'hFF), th + 8'h01, 8'h00};
            else
              step = {1'b0, th, (tl & mask) + 8'h01};
          end
          `MODE_AUTO16: begin
            if ({th, tl} == 16'hFFFF)
              step = {1'b1, rh, rl};
            else
              step = {1'b0, {th, tl} + 16'h0001};
          end
          `MODE_AUTO8: begin
            if (tl == 8'hFF)
              step = {1'b1, th, th};
            else
              step = {1'b0, th, tl + 8'h01};
          end
          default: begin
            // split: low byte alone, high byte handled by caller
            if (tl == 8'hFF)
              step = {1'b1, th, 8'h00};
            else
              step = {1'b0, th, tl + 8'h01};
          end
        endcase
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; write lands on the edge at which pready is sampled high

  // access is the first cycle of the access phase; done is the answer cycle
  // a registered answer costs one wait state but keeps every output a flop
  // the low two address bits are ignored, so any byte lane reaches the word
  wire access = PSEL & PENABLE & ~PREADY;
  wire done = PSEL & PENABLE & PREADY;
  wire wr = done & PWRITE;
  wire [9:0] index = PADDR[11:2];
  // control write strobe as a plain net, so the combinational block sees it change
  wire ctl_wr = wr & (index == {2'h0, `IDX_TIMER_CONTROL});

  function wsel;
    input [7:0] idx;
    begin
      wsel = wr & (index == {2'h0, idx});
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // count enables
  // a timer ticks when it runs, its gate is open and its source has an event; the second timer never ticks in mode 11
  // the count pins are taken as synchronous; a stray fall from reset is
  // avoided because the stored sample starts low and a fall needs a high first

  wire [1:0] mode0 = mod_q[`MOD_FIRST_MODE_HI:`MOD_FIRST_MODE_LO];
  wire [1:0] mode1 = mod_q[`MOD_SECOND_MODE_HI:`MOD_SECOND_MODE_LO];
  wire run0 = ctl_q[`CTL_FIRST_RUN];
  wire run1 = ctl_q[`CTL_SECOND_RUN];
  // pins are synchronous; one stored sample gives the falling edge
  wire cnt0_fall = cnt0_prev_q & ~FIRST_COUNT_PIN;
  wire cnt1_fall = cnt1_prev_q & ~SECOND_COUNT_PIN;
  wire first_pin_gating_ok = ~mod_q[`MOD_FIRST_GATE] | FIRST_EXT_IRQ_PIN;
  wire second_pin_gating_ok = ~mod_q[`MOD_SECOND_GATE] | SECOND_EXT_IRQ_PIN;
  wire src0 = mod_q[`MOD_FIRST_CSEL] ? cnt0_fall : 1'b1;
  wire src1 = mod_q[`MOD_SECOND_CSEL] ? cnt1_fall : 1'b1;
  wire tick0 = run0 & first_pin_gating_ok & src0;
  // second timer halts completely in its mode 11
  wire tick1 = run1 & second_pin_gating_ok & src1 & (mode1 != `MODE_SPLIT);
  wire split = (mode0 == `MODE_SPLIT);
  // split high byte is a plain timer on the second run bit
  wire tick_hi = split & run1;

  wire [16:0] s0 = step(mode0, xmode_q[`XM_FIRST_WIDTH_HI:`XM_FIRST_WIDTH_LO],
                        tick0, tl0_q, th0_q, rl0_q, rh0_q);
  wire [16:0] s1 = step(mode1, xmode_q[`XM_SECOND_WIDTH_HI:`XM_SECOND_WIDTH_LO],
                        tick1, tl1_q, th1_q, rl1_q, rh1_q);
  wire hi_ovf = tick_hi & (th0_q == 8'hFF);
  wire [7:0] th0_next = tick_hi ? th0_q + 8'h01 : s0[15:8];
  wire ovf0 = s0[16];
  // in split mode the second flag belongs to the first timer's high byte
  wire ovf1 = split ? hi_ovf : s1[16];

  ////////////////////////////////////////////////////////////////////////////
  // external interrupt detection
  // edge type compares with the stored sample, which resets high like the pin,
  // so releasing reset with the pin idle never reports a false edge
  // level type keeps setting the flag for as long as the pin stays low

  wire edge0_set = ctl_q[`CTL_FIRST_TYPE] ? (irq0_prev_q & ~FIRST_EXT_IRQ_PIN)
                                          : ~FIRST_EXT_IRQ_PIN;
  wire edge1_set = ctl_q[`CTL_SECOND_TYPE] ? (irq1_prev_q & ~SECOND_EXT_IRQ_PIN)
                                           : ~SECOND_EXT_IRQ_PIN;
  wire [3:0] events = {edge1_set, edge0_set, ovf1, ovf0};

  ////////////////////////////////////////////////////////////////////////////
  // next control value: writes load, acks clear, hardware set wins
  // the sets come last on purpose: an event in the same cycle as an ack or a
  // software clear must not be lost, so software may see a flag it just cleared

  always @* begin
    ctl_d = ctl_q;
    if (ctl_wr)
      ctl_d = PWDATA[7:0];
    if (SECOND_OVF_ACK)
      ctl_d[`CTL_SECOND_OVF] = 1'b0;
    if (FIRST_OVF_ACK)
      ctl_d[`CTL_FIRST_OVF] = 1'b0;
    if (SECOND_EDGE_ACK)
      ctl_d[`CTL_SECOND_EDGE] = 1'b0;
    if (FIRST_EDGE_ACK)
      ctl_d[`CTL_FIRST_EDGE] = 1'b0;
    if (ovf1)
      ctl_d[`CTL_SECOND_OVF] = 1'b1;
    if (ovf0)
      ctl_d[`CTL_FIRST_OVF] = 1'b1;
    if (edge1_set)
      ctl_d[`CTL_SECOND_EDGE] = 1'b1;
    if (edge0_set)
      ctl_d[`CTL_FIRST_EDGE] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped index answers with an error and zero data

  always @* begin
    rdata = 32'h00000000;
    hit = 1'b1;
    case (index)
      {2'h0, `IDX_TIMER_CONTROL}: rdata[7:0] = ctl_q;
      {2'h0, `IDX_TIMER_MODE_SELECT}: rdata[7:0] = mod_q;
      {2'h0, `IDX_FIRST_COUNT_LOW}: rdata[7:0] = tl0_q;
      {2'h0, `IDX_SECOND_COUNT_LOW}: rdata[7:0] = tl1_q;
      {2'h0, `IDX_FIRST_COUNT_HIGH}: rdata[7:0] = th0_q;
      {2'h0, `IDX_SECOND_COUNT_HIGH}: rdata[7:0] = th1_q;
      {2'h0, `IDX_TIMER_EXTRA_MODE}: rdata[7:0] = xmode_q;
      {2'h0, `IDX_FIRST_RELOAD_LOW}: rdata[7:0] = rl0_q;
      {2'h0, `IDX_SECOND_RELOAD_LOW}: rdata[7:0] = rl1_q;
      {2'h0, `IDX_FIRST_RELOAD_HIGH}: rdata[7:0] = rh0_q;
      {2'h0, `IDX_SECOND_RELOAD_HIGH}: rdata[7:0] = rh1_q;
      {2'h0, `IDX_EVENT_STATUS}: rdata[3:0] = status_q;
      {2'h0, `IDX_EVENT_CLEAR}: rdata[3:0] = 4'h0; // write-only
      {2'h0, `IDX_EVENT_ENABLE}: rdata[3:0] = enable_q;
      default: hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus response: one wait state, all outputs registered
  // read data is latched in the access cycle and is zero outside the answer
  // an unmapped index answers with an error and leaves every register alone

  always @(posedge CORE_CLK) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= access;
      PRDATA <= access ? rdata : 32'h00000000;
      PSLVERR <= access & ~hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, mode and interrupt registers

  always @(posedge CORE_CLK) begin
    if (!RST_B) begin
      ctl_q <= `RST_TIMER_CONTROL;
      mod_q <= `RST_TIMER_MODE_SELECT;
      xmode_q <= `RST_TIMER_EXTRA_MODE;
      status_q <= 4'h0;
      enable_q <= 4'h0;
      IRQ <= 1'b0;
      irq0_prev_q <= 1'b1;
      irq1_prev_q <= 1'b1;
      cnt0_prev_q <= 1'b0;
      cnt1_prev_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      if (wsel(`IDX_TIMER_MODE_SELECT))
        mod_q <= PWDATA[7:0];
      if (wsel(`IDX_TIMER_EXTRA_MODE))
        xmode_q <= PWDATA[7:0];
      if (wsel(`IDX_EVENT_ENABLE))
        enable_q <= PWDATA[3:0];
      // clear by write of ones; a same-cycle event keeps its bit
      status_q <= (status_q & ~(wsel(`IDX_EVENT_CLEAR) ? PWDATA[3:0] : 4'h0)) | events;
      // one cycle late on purpose so the pin is a flop
      IRQ <= |(status_q & enable_q);
      irq0_prev_q <= FIRST_EXT_IRQ_PIN;
      irq1_prev_q <= SECOND_EXT_IRQ_PIN;
      cnt0_prev_q <= FIRST_COUNT_PIN;
      cnt1_prev_q <= SECOND_COUNT_PIN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag outputs mirror the control register flops

  always @(posedge CORE_CLK) begin
    if (!RST_B) begin
      FIRST_OVERFLOW_FLAG <= 1'b0;
      SECOND_OVERFLOW_FLAG <= 1'b0;
      FIRST_EDGE_FLAG <= 1'b0;
      SECOND_EDGE_FLAG <= 1'b0;
    end else begin
      FIRST_OVERFLOW_FLAG <= ctl_d[`CTL_FIRST_OVF];
      SECOND_OVERFLOW_FLAG <= ctl_d[`CTL_SECOND_OVF];
      FIRST_EDGE_FLAG <= ctl_d[`CTL_FIRST_EDGE];
      SECOND_EDGE_FLAG <= ctl_d[`CTL_SECOND_EDGE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count and reload bytes; a software write beats a count in that cycle
  // in split mode the first high byte follows the second run bit instead
  // of the first timer's step, which leaves that byte untouched there
  // reload bytes keep their value in every mode and can serve as storage

  always @(posedge CORE_CLK) begin
    if (!RST_B) begin
      tl0_q <= `RST_COUNT;
      th0_q <= `RST_COUNT;
      tl1_q <= `RST_COUNT;
      th1_q <= `RST_COUNT;
      rl0_q <= `RST_RELOAD;
      rh0_q <= `RST_RELOAD;
      rl1_q <= `RST_RELOAD;
      rh1_q <= `RST_RELOAD;
    end else begin
      tl0_q <= wsel(`IDX_FIRST_COUNT_LOW) ? PWDATA[7:0] : s0[7:0];
      th0_q <= wsel(`IDX_FIRST_COUNT_HIGH) ? PWDATA[7:0] : th0_next;
      tl1_q <= wsel(`IDX_SECOND_COUNT_LOW) ? PWDATA[7:0] : s1[7:0];
      th1_q <= wsel(`IDX_SECOND_COUNT_HIGH) ? PWDATA[7:0] : s1[15:8];
      // reload bytes are only read by the timer in mode 01
      if (wsel(`IDX_FIRST_RELOAD_LOW))
        rl0_q <= PWDATA[7:0];
      if (wsel(`IDX_FIRST_RELOAD_HIGH))
        rh0_q <= PWDATA[7:0];
      if (wsel(`IDX_SECOND_RELOAD_LOW))
        rl1_q <= PWDATA[7:0];
      if (wsel(`IDX_SECOND_RELOAD_HIGH))
        rh1_q <= PWDATA[7:0];
    end
  end

endmodule

//--- hw/timer_regs.vh
// register indices, field positions, reset values and codes of the dual timer
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH
// register indices; byte address on the bus is four times the index
`define IDX_TIMER_CONTROL 8'h88
`define IDX_TIMER_MODE_SELECT 8'h89
`define IDX_FIRST_COUNT_LOW 8'h8A
`define IDX_SECOND_COUNT_LOW 8'h8B
`define IDX_FIRST_COUNT_HIGH 8'h8C
`define IDX_SECOND_COUNT_HIGH 8'h8D
`define IDX_TIMER_EXTRA_MODE 8'h91
`define IDX_FIRST_RELOAD_LOW 8'hF2
`define IDX_SECOND_RELOAD_LOW 8'hF3
`define IDX_FIRST_RELOAD_HIGH 8'hF4
`define IDX_SECOND_RELOAD_HIGH 8'hF5
`define IDX_EVENT_STATUS 8'hA0
`define IDX_EVENT_CLEAR 8'hA1
`define IDX_EVENT_ENABLE 8'hA2
// timer_control fields
`define CTL_SECOND_OVF 7
`define CTL_SECOND_RUN 6
`define CTL_FIRST_OVF 5
`define CTL_FIRST_RUN 4
`define CTL_SECOND_EDGE 3
`define CTL_SECOND_TYPE 2
`define CTL_FIRST_EDGE 1
`define CTL_FIRST_TYPE 0
// timer_mode_select fields
`define MOD_SECOND_GATE 7
`define MOD_SECOND_CSEL 6
`define MOD_SECOND_MODE_HI 5
`define MOD_SECOND_MODE_LO 4
`define MOD_FIRST_GATE 3
`define MOD_FIRST_CSEL 2
`define MOD_FIRST_MODE_HI 1
`define MOD_FIRST_MODE_LO 0
// timer_extra_mode width fields
`define XM_SECOND_WIDTH_HI 5
`define XM_SECOND_WIDTH_LO 3
`define XM_FIRST_WIDTH_HI 2
`define XM_FIRST_WIDTH_LO 0
// event status bit positions
`define EV_FIRST_OVF 0
`define EV_SECOND_OVF 1
`define EV_FIRST_EDGE 2
`define EV_SECOND_EDGE 3
// reset values
`define RST_TIMER_CONTROL 8'h00
`define RST_TIMER_MODE_SELECT 8'h00
`define RST_TIMER_EXTRA_MODE 8'h24
`define RST_COUNT 8'h00
`define RST_RELOAD 8'h00
// operating modes
`define MODE_VAR 2'h0
`define MODE_AUTO16 2'h1
`define MODE_AUTO8 2'h2
`define MODE_SPLIT 2'h3
`endif

//--- verif/dual_timer_assertions.sv
// port checker for the dual timer, bound to its top module
`timescale 1ns/1ps
module dual_timer_assertions (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_B,
  // apb
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire PREADY,
  input wire [31:0] PRDATA,
  input wire PSLVERR,
  // pins and flags
  input wire FIRST_EXT_IRQ_PIN,
  input wire SECOND_EXT_IRQ_PIN,
  input wire FIRST_OVERFLOW_FLAG,
  input wire SECOND_OVERFLOW_FLAG,
  input wire FIRST_EDGE_FLAG,
  input wire SECOND_EDGE_FLAG,
  input wire IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // access phase still waiting for its answer
  sequence s_wait;
    PSEL && PENABLE && !PREADY;
  endsequence
  // a software write may also set a flag, so it counts as a cause
  sequence s_wr;
    PSEL && PENABLE && PWRITE;
  endsequence
  AST_READY_WAIT: assert property (s_wait |=> PREADY)
    else $error("no answer one cycle after access");
  AST_READY_ONE: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  AST_READY_CAUSE: assert property (PREADY |-> $past(PSEL && PENABLE))
    else $error("ready without an access");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
    else $error("error response without ready");
  AST_DATA_IDLE: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data not zero outside answer");
  AST_RESET_CLEAR: assert property (disable iff (1'b0)
    !RST_B |=> !IRQ && !FIRST_OVERFLOW_FLAG
    && !SECOND_OVERFLOW_FLAG && !FIRST_EDGE_FLAG && !SECOND_EDGE_FLAG)
    else $error("flags or interrupt set after reset");
  AST_FIRST_EDGE_CAUSE: assert property ($rose(FIRST_EDGE_FLAG) |->
    !$past(FIRST_EXT_IRQ_PIN) || $past(PSEL && PENABLE && PWRITE))
    else $error("first edge flag set with pin high");
  AST_SECOND_EDGE_CAUSE: assert property ($rose(SECOND_EDGE_FLAG) |->
    !$past(SECOND_EXT_IRQ_PIN) || $past(PSEL && PENABLE && PWRITE))
    else $error("second edge flag set with pin high");
  COV_WRITE: cover property (s_wr ##1 PREADY);
endmodule
bind dual_timer dual_timer_assertions u_chk (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .FIRST_EXT_IRQ_PIN(FIRST_EXT_IRQ_PIN), .SECOND_EXT_IRQ_PIN(SECOND_EXT_IRQ_PIN),
  .FIRST_OVERFLOW_FLAG(FIRST_OVERFLOW_FLAG), .SECOND_OVERFLOW_FLAG(SECOND_OVERFLOW_FLAG),
  .FIRST_EDGE_FLAG(FIRST_EDGE_FLAG), .SECOND_EDGE_FLAG(SECOND_EDGE_FLAG), .IRQ(IRQ));

//--- verif/pin_model.sv
// far-side model of the count pins and external interrupt pins
`timescale 1ns/1ps
module pin_model (
  // clock
  input wire clk,
  // requests from the bench
  input wire [1:0] go,
  input wire [1:0] lvl,
  // pins
  output reg [1:0] count_pin,
  output reg [1:0] irq_pin
);
  // pins idle high (pull-up); each level lasts a full cycle so no fall is missed
  initial begin
    count_pin = 2'h3;
    irq_pin = 2'h3;
  end
  always @(posedge clk) begin
    count_pin <= (go & ~count_pin) | ~go;
    irq_pin <= lvl;
  end
endmodule

//--- verif/dual_timer_tb.sv
// self-checking bench for the dual timer
`timescale 1ns/1ps
`include "timer_regs.vh"
module dual_timer_tb;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] ack = 4'h0;
  reg [1:0] go = 2'h0, lvl = 2'h3;
  wire pready, pslverr, irq, ovf1, ovf2, edge1, edge2;
  wire [31:0] prdata;
  wire [1:0] cpin, ipin;
  integer n_mismatch = 0, samples_checked = 0, n;
  reg [8:0] notes [$];
  reg [7:0] r;
  always #4 clk = ~clk;
  dual_timer u_dut (.CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .FIRST_EXT_IRQ_PIN(ipin[0]), .SECOND_EXT_IRQ_PIN(ipin[1]),
    .FIRST_COUNT_PIN(cpin[0]), .SECOND_COUNT_PIN(cpin[1]), .FIRST_OVF_ACK(ack[0]),
    .SECOND_OVF_ACK(ack[1]), .FIRST_EDGE_ACK(ack[2]), .SECOND_EDGE_ACK(ack[3]),
    .FIRST_OVERFLOW_FLAG(ovf1), .SECOND_OVERFLOW_FLAG(ovf2), .FIRST_EDGE_FLAG(edge1),
    .SECOND_EDGE_FLAG(edge2), .IRQ(irq));
  pin_model u_pins (.clk(clk), .go(go), .lvl(lvl), .count_pin(cpin), .irq_pin(ipin));
  task check(input string nm, input [8:0] e, input [8:0] s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task flag(input string nm, input e, input s);
    check(nm, {8'h00, e}, {8'h00, s});
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one apb transfer; the request is held until ready is seen at an edge
  task apb(input w, input [7:0] idx, input [7:0] d);
    integer i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk) penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (!pready && i < 20);
    if (i >= 20) begin
      n_mismatch++;
      finish_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input [7:0] idx, input [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task rd(input [7:0] idx, input [8:0] e);
    notes.push_back(e);
    apb(1'b0, idx, 8'h00);
  endtask
  task pulse(input [1:0] p, input integer k);
    go <= p;
    repeat (2 * k) @(posedge clk);
    go <= 2'h0;
    repeat (3) @(posedge clk);
  endtask
  // read answers are matched against the oldest note
  always @(posedge clk) begin
    if (pready && !pwrite) begin
      if (notes.size() == 0)
        check("read note", 9'h1FF, 9'h000);
      else
        check("read", notes.pop_front(), {pslverr, prdata[7:0]});
    end
  end
  initial begin
    r = $urandom(32'hA8543462);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(`IDX_TIMER_CONTROL, 9'h000);
    rd(`IDX_TIMER_MODE_SELECT, 9'h000);
    rd(`IDX_TIMER_EXTRA_MODE, {1'b0, `RST_TIMER_EXTRA_MODE});
    wr(`IDX_FIRST_RELOAD_LOW, 8'h5A);
    rd(`IDX_FIRST_RELOAD_LOW, 9'h05A);
    rd(8'h00, 9'h100);
    $display("test reset and storage done");
    n = $urandom_range(5, 2);
    r = $urandom;
    wr(`IDX_EVENT_ENABLE, 8'h0F);
    wr(`IDX_TIMER_MODE_SELECT, 8'h06);
    wr(`IDX_FIRST_COUNT_LOW, 8'h00 - n[7:0]);
    wr(`IDX_FIRST_COUNT_HIGH, r);
    wr(`IDX_TIMER_CONTROL, 8'h10);
    pulse(2'h1, n - 1);
    flag("ovf1 early", 1'b0, ovf1);
    pulse(2'h1, 1);
    flag("ovf1", 1'b1, ovf1);
    flag("irq", 1'b1, irq);
    rd(`IDX_FIRST_COUNT_LOW, {1'b0, r});
    rd(`IDX_EVENT_STATUS, 9'h001);
    ack <= 4'h1;
    @(posedge clk) ack <= 4'h0;
    @(posedge clk);
    flag("ovf1 ack", 1'b0, ovf1);
    wr(`IDX_EVENT_ENABLE, 8'h00);
    @(posedge clk);
    flag("irq masked", 1'b0, irq);
    wr(`IDX_EVENT_ENABLE, 8'h0F);
    @(posedge clk);
    flag("irq unmasked", 1'b1, irq);
    wr(`IDX_EVENT_CLEAR, 8'h01);
    @(posedge clk);
    flag("irq cleared", 1'b0, irq);
    $display("test mode 10 and interrupt done");
    wr(`IDX_TIMER_CONTROL, 8'h00);
    wr(`IDX_SECOND_RELOAD_LOW, r);
    wr(`IDX_SECOND_RELOAD_HIGH, ~r);
    wr(`IDX_TIMER_MODE_SELECT, 8'h50);
    wr(`IDX_SECOND_COUNT_LOW, 8'hFF);
    wr(`IDX_SECOND_COUNT_HIGH, 8'hFF);
    wr(`IDX_TIMER_CONTROL, 8'h40);
    pulse(2'h2, 1);
    flag("ovf2", 1'b1, ovf2);
    rd(`IDX_SECOND_COUNT_LOW, {1'b0, r});
    rd(`IDX_SECOND_COUNT_HIGH, {1'b0, ~r});
    lvl <= 2'h1;
    wr(`IDX_TIMER_MODE_SELECT, 8'hD0);
    pulse(2'h2, 2);
    rd(`IDX_SECOND_COUNT_LOW, {1'b0, r});
    flag("edge2 level", 1'b1, edge2);
    lvl <= 2'h3;
    pulse(2'h2, 1);
    rd(`IDX_SECOND_COUNT_LOW, {1'b0, r + 8'h01});
    wr(`IDX_TIMER_CONTROL, 8'h00);
    pulse(2'h2, 1);
    rd(`IDX_SECOND_COUNT_LOW, {1'b0, r + 8'h01});
    wr(`IDX_TIMER_MODE_SELECT, 8'h70);
    wr(`IDX_TIMER_CONTROL, 8'h40);
    pulse(2'h2, 1);
    rd(`IDX_SECOND_COUNT_LOW, {1'b0, r + 8'h01});
    $display("test second timer done");
    wr(`IDX_TIMER_CONTROL, 8'h01);
    lvl <= 2'h2;
    repeat (3) @(posedge clk);
    flag("edge1 fall", 1'b1, edge1);
    ack <= 4'h4;
    @(posedge clk) ack <= 4'h0;
    repeat (3) @(posedge clk);
    flag("edge1 ack", 1'b0, edge1);
    wr(`IDX_TIMER_CONTROL, 8'h00);
    @(posedge clk);
    flag("edge1 level", 1'b1, edge1);
    lvl <= 2'h3;
    $display("test external interrupt done");
    // mode 00, default width of 5 low bits: FE masks to 1E, wraps after 2 ticks
    wr(`IDX_TIMER_MODE_SELECT, 8'h00);
    wr(`IDX_FIRST_COUNT_LOW, 8'hFE);
    wr(`IDX_FIRST_COUNT_HIGH, 8'hFF);
    wr(`IDX_TIMER_CONTROL, 8'h10);
    repeat (2) @(posedge clk);
    flag("ovf1 mode 00", 1'b1, ovf1);
    wr(`IDX_TIMER_CONTROL, 8'h00);
    rd(`IDX_FIRST_COUNT_LOW, 9'h004);
    rd(`IDX_FIRST_COUNT_HIGH, 9'h000);
    // split: first high byte runs on the second run bit and sets the second flag
    wr(`IDX_TIMER_MODE_SELECT, 8'h03);
    wr(`IDX_FIRST_COUNT_LOW, 8'h33);
    wr(`IDX_FIRST_COUNT_HIGH, 8'hFE);
    wr(`IDX_TIMER_CONTROL, 8'h40);
    repeat (2) @(posedge clk);
    flag("ovf2 split", 1'b1, ovf2);
    wr(`IDX_TIMER_CONTROL, 8'h00);
    rd(`IDX_FIRST_COUNT_LOW, 9'h033);
    $display("test mode 00 and split done");
    finish_test;
  end
endmodule
